/* rtl/lmd_pkg.sv */
package lmd_pkg;

  // ****************************************************************
  // Operand sources and destinations
  // ****************************************************************
  typedef enum logic [3:0] {
    LMD_LOC_NONE     = 4'b0000,
    LMD_LOC_ACC      = 4'b0001,
    LMD_LOC_REG      = 4'b0010,
    LMD_LOC_DIRECT   = 4'b0011,
    LMD_LOC_INDIRECT = 4'b0100,
    LMD_LOC_IMM      = 4'b0101,
    LMD_LOC_IMM16    = 4'b0110,
    LMD_LOC_CODE_DP  = 4'b0111,
    LMD_LOC_CODE_PC  = 4'b1000,
    LMD_LOC_EXT_RI   = 4'b1001,
    LMD_LOC_EXT_DP   = 4'b1010,
    LMD_LOC_STACK    = 4'b1011,
    LMD_LOC_DATA_PTR = 4'b1100
  } lmd_loc_t;

  // ****************************************************************
  // Result functions of the execute stage
  // ****************************************************************
  typedef enum logic [3:0] {
    LMD_FN_PASS   = 4'b0000,
    LMD_FN_AND    = 4'b0001,
    LMD_FN_OR     = 4'b0010,
    LMD_FN_XOR    = 4'b0011,
    LMD_FN_ZERO   = 4'b0100,
    LMD_FN_INVERT = 4'b0101,
    LMD_FN_ROL    = 4'b0110,
    LMD_FN_ROLC   = 4'b0111,
    LMD_FN_ROR    = 4'b1000,
    LMD_FN_RORC   = 4'b1001,
    LMD_FN_SWAP   = 4'b1010,
    LMD_FN_TRADE  = 4'b1011,
    LMD_FN_DIGIT  = 4'b1100
  } lmd_fn_t;

  // ****************************************************************
  // Decoded instruction word
  // ****************************************************************
  typedef struct packed {
    logic     legal;
    lmd_fn_t  fn;
    lmd_loc_t src;
    lmd_loc_t dst;
    logic [1:0] bytes;
    logic [1:0] cycles;
    logic [2:0] reg_idx;
  } lmd_dec_t;

  // ****************************************************************
  // Field positions and constants
  // ****************************************************************
  localparam int         LMD_LO_REG_BIT  = 3;
  localparam logic [3:0] LMD_LO_IMM      = 4'h4;
  localparam logic [3:0] LMD_LO_DIRECT   = 4'h5;
  localparam logic [3:0] LMD_LO_SPECIAL  = 4'h3;
  localparam logic [1:0] LMD_ONE         = 2'h1;
  localparam logic [1:0] LMD_TWO         = 2'h2;
  localparam logic [1:0] LMD_THREE       = 2'h3;
  localparam logic [7:0] LMD_BYTE_ZERO   = 8'h00;
  localparam logic [15:0] LMD_PTR_RESET  = 16'h0000;
  localparam int         LMD_MCYCLE_CLKS = 1;

endpackage : lmd_pkg

/* rtl/lmd_decoder.sv */
// How it works
// - AND into accumulator: 5x reg, 55 direct, 56/57 indirect, 54 immediate; one cycle.
// - AND into direct byte: 52 from accumulator, 53 from immediate taking three bytes and two cycles.
// - OR into accumulator: 4x reg, 45 direct, 46/47 indirect, 44 immediate; one cycle.
// - OR into direct byte: 42 from accumulator, 43 from immediate taking two cycles.
// - XOR into accumulator: 6x reg, 65 direct, 66/67 indirect, 64 immediate; one cycle.
// - XOR into direct byte: 62 from accumulator, 63 from immediate taking two cycles.
// - Opcode 23 rotates left, 33 rotates left through carry; one byte, one cycle.
// - Opcode 03 rotates right, 13 rotates right through carry; one byte, one cycle.
// - Opcode C4 swaps accumulator nibbles in one cycle.
// - Accumulator loads: Ex reg, E5 direct, E6/E7 indirect, 74 immediate; one cycle.
// - Bank register writes: Fx from accumulator, Ax from direct, 7x from immediate.
// - Direct writes: F5 accumulator, 8x reg, 86/87 indirect, 85 direct, 75 immediate.
// - Indirect writes: F6/F7 accumulator, A6/A7 direct, 76/77 immediate.
// - Opcode 90 loads the 16-bit data pointer; three bytes, two cycles.
// - Code reads at accumulator plus data pointer (93) or program counter (83).
// - External reads: E2/E3 8-bit pointer address, E0 data pointer; two cycles.
// - External writes: F2/F3 8-bit pointer address, F0 data pointer; two cycles.
// - C0 pushes a direct byte, D0 pops one; two bytes, two cycles.
// - Accumulator trades with reg (Cx), direct (C5) or indirect (C6/C7) in one cycle.
// - D6/D7 trade only the low nibbles of accumulator and indirect byte.
// - Low nibble 8 to F selects bank register 0 to 7.
// - Indirect operands use register 0 or 1 of the current bank, by opcode bit 0.
// - A 16-bit constant comes from instruction bytes two and three.
module lmd_decoder
  import lmd_pkg::*;
#(
  parameter int MCYCLE_CLKS = LMD_MCYCLE_CLKS
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Instruction from the fetch stage.
  input  wire logic        start,
  input  wire logic [7:0]  opcode,
  input  wire logic [7:0]  byte2,
  input  wire logic [7:0]  byte3,
  // Core state and fetched operands.
  input  wire logic [7:0]  working_byte_in,
  input  wire logic        carry_in,
  input  wire logic [7:0]  src_data,
  input  wire logic [7:0]  dst_data,
  input  wire logic [7:0]  pointer_value,
  input  wire logic [1:0]  bank_sel,
  input  wire logic [15:0] pc_in,
  // Decode and results.
  output logic             busy,
  output logic             done,
  output lmd_dec_t         dec,
  output logic [7:0]       working_byte_out,
  output logic [7:0]       wr_data,
  output logic             carry_out,
  output logic [15:0]      data_pointer,
  output logic [15:0]      code_addr,
  output logic [15:0]      ext_addr,
  output logic [7:0]       reg_addr
);

  // ****************************************************************
  // Decode functions
  // ****************************************************************

  // Operand mode of the shared low-nibble pattern 4..F.
  function automatic lmd_loc_t lmd_mode(input logic [3:0] lo);
    if (lo[LMD_LO_REG_BIT]) begin
      lmd_mode = LMD_LOC_REG;
    end else if (lo == LMD_LO_IMM) begin
      lmd_mode = LMD_LOC_IMM;
    end else if (lo == LMD_LO_DIRECT) begin
      lmd_mode = LMD_LOC_DIRECT;
    end else begin
      lmd_mode = LMD_LOC_INDIRECT;
    end
  endfunction : lmd_mode

  // Full opcode decode; codes outside this block come back not legal.
  function automatic lmd_dec_t lmd_decode(input logic [7:0] op);
    lmd_dec_t   d;
    logic [3:0] hi;
    logic [3:0] lo;
    logic       ind;
    logic       ge4;
    d = '0;
    hi = op[7:4];
    lo = op[3:0];
    ind = (lo[3:1] == 3'b011);
    ge4 = (lo >= LMD_LO_IMM);
    d.fn = LMD_FN_PASS;
    d.src = LMD_LOC_NONE;
    d.dst = LMD_LOC_NONE;
    d.bytes = LMD_ONE;
    d.cycles = LMD_ONE;
    d.reg_idx = lo[LMD_LO_REG_BIT] ? lo[2:0] : {2'b00, lo[0]};
    unique case (hi)
      4'h4, 4'h5, 4'h6: begin
        d.fn = (hi == 4'h4) ? LMD_FN_OR : (hi == 4'h5) ? LMD_FN_AND : LMD_FN_XOR;
        if (ge4) begin
          d.src = lmd_mode(lo);
          d.dst = LMD_LOC_ACC;
          d.bytes = (lo == LMD_LO_IMM || lo == LMD_LO_DIRECT) ? LMD_TWO : LMD_ONE;
        end else if (lo == 4'h2) begin
          d.src = LMD_LOC_ACC;
          d.dst = LMD_LOC_DIRECT;
          d.bytes = LMD_TWO;
        end else if (lo == LMD_LO_SPECIAL) begin
          d.src = LMD_LOC_IMM;
          d.dst = LMD_LOC_DIRECT;
          d.bytes = LMD_THREE;
          d.cycles = LMD_TWO;
        end else begin
          d.fn = LMD_FN_PASS;
        end
      end
      4'h0: d.fn = (lo == LMD_LO_SPECIAL) ? LMD_FN_ROR : LMD_FN_PASS;
      4'h1: d.fn = (lo == LMD_LO_SPECIAL) ? LMD_FN_RORC : LMD_FN_PASS;
      4'h2: d.fn = (lo == LMD_LO_SPECIAL) ? LMD_FN_ROL : LMD_FN_PASS;
      4'h3: d.fn = (lo == LMD_LO_SPECIAL) ? LMD_FN_ROLC : LMD_FN_PASS;
      4'h7: if (ge4) begin
        d.src = LMD_LOC_IMM;
        d.dst = (lo == LMD_LO_IMM) ? LMD_LOC_ACC : lmd_mode(lo);
        d.bytes = (lo == LMD_LO_DIRECT) ? LMD_THREE : LMD_TWO;
        d.cycles = (lo == LMD_LO_DIRECT) ? LMD_TWO : LMD_ONE;
      end
      4'h8: if (lo == LMD_LO_SPECIAL) begin
        d.src = LMD_LOC_CODE_PC;
        d.dst = LMD_LOC_ACC;
        d.cycles = LMD_TWO;
      end else if (lo >= LMD_LO_DIRECT) begin
        d.src = lmd_mode(lo);
        d.dst = LMD_LOC_DIRECT;
        d.bytes = (lo == LMD_LO_DIRECT) ? LMD_THREE : LMD_TWO;
        d.cycles = LMD_TWO;
      end
      4'h9: if (lo == 4'h0) begin
        d.src = LMD_LOC_IMM16;
        d.dst = LMD_LOC_DATA_PTR;
        d.bytes = LMD_THREE;
        d.cycles = LMD_TWO;
      end else if (lo == LMD_LO_SPECIAL) begin
        d.src = LMD_LOC_CODE_DP;
        d.dst = LMD_LOC_ACC;
        d.cycles = LMD_TWO;
      end
      4'hA: if (lo[LMD_LO_REG_BIT] || ind) begin
        d.src = LMD_LOC_DIRECT;
        d.dst = lmd_mode(lo);
        d.bytes = LMD_TWO;
        d.cycles = LMD_TWO;
      end
      4'hC, 4'hD: if (lo == 4'h0) begin
        d.src = (hi == 4'hC) ? LMD_LOC_DIRECT : LMD_LOC_STACK;
        d.dst = (hi == 4'hC) ? LMD_LOC_STACK : LMD_LOC_DIRECT;
        d.bytes = LMD_TWO;
        d.cycles = LMD_TWO;
      end else if (hi == 4'hC && lo == LMD_LO_IMM) begin
        d.fn = LMD_FN_SWAP;
      end else if ((hi == 4'hC && lo >= LMD_LO_DIRECT) || (hi == 4'hD && ind)) begin
        d.fn = (hi == 4'hC) ? LMD_FN_TRADE : LMD_FN_DIGIT;
        d.src = lmd_mode(lo);
        d.dst = LMD_LOC_ACC;
        d.bytes = (lo == LMD_LO_DIRECT) ? LMD_TWO : LMD_ONE;
      end
      4'hE, 4'hF: if (lo == 4'h0 || lo[3:1] == 3'b001) begin
        d.src = (hi == 4'hE) ? ((lo == 4'h0) ? LMD_LOC_EXT_DP : LMD_LOC_EXT_RI) : LMD_LOC_ACC;
        d.dst = (hi == 4'hF) ? ((lo == 4'h0) ? LMD_LOC_EXT_DP : LMD_LOC_EXT_RI) : LMD_LOC_ACC;
        d.cycles = LMD_TWO;
      end else if (lo == LMD_LO_IMM) begin
        d.fn = (hi == 4'hE) ? LMD_FN_ZERO : LMD_FN_INVERT;
      end else if (ge4) begin
        d.src = (hi == 4'hE) ? lmd_mode(lo) : LMD_LOC_ACC;
        d.dst = (hi == 4'hE) ? LMD_LOC_ACC : lmd_mode(lo);
        d.bytes = (lo == LMD_LO_DIRECT) ? LMD_TWO : LMD_ONE;
      end
      default: d.legal = 1'b0;
    endcase
    d.legal = (d.src != LMD_LOC_NONE) || (d.fn != LMD_FN_PASS);
    return d;
  endfunction : lmd_decode

  // ****************************************************************
  // Execute datapath
  // ****************************************************************
  logic       take;
  lmd_dec_t   dec_next;
  logic [7:0] x_val;
  logic [7:0] y_val;
  logic [7:0] acc_next;
  logic [7:0] wr_next;
  logic       carry_next;

  assign take = start && !busy;
  assign dec_next = lmd_decode(opcode);

  // Destination value and source value; a three-byte immediate form carries the data last.
  always_comb begin
    x_val = (dec_next.dst == LMD_LOC_ACC || dec_next.dst == LMD_LOC_NONE) ? working_byte_in : dst_data;
    if (dec_next.src == LMD_LOC_ACC) begin
      y_val = working_byte_in;
    end else if (dec_next.src == LMD_LOC_IMM) begin
      y_val = (dec_next.bytes == LMD_THREE) ? byte3 : byte2;
    end else begin
      y_val = src_data;
    end
  end

  // Results for the accumulator, for the written location and for the carry flag.
  always_comb begin
    acc_next = working_byte_in;
    wr_next = y_val;
    carry_next = carry_in;
    unique case (dec_next.fn)
      LMD_FN_AND:    wr_next = x_val & y_val;
      LMD_FN_OR:     wr_next = x_val | y_val;
      LMD_FN_XOR:    wr_next = x_val ^ y_val;
      LMD_FN_ZERO:   wr_next = LMD_BYTE_ZERO;
      LMD_FN_INVERT: wr_next = ~working_byte_in;
      LMD_FN_ROL:    wr_next = {working_byte_in[6:0], working_byte_in[7]};
      LMD_FN_ROLC: begin
        wr_next = {working_byte_in[6:0], carry_in};
        carry_next = working_byte_in[7];
      end
      LMD_FN_ROR:    wr_next = {working_byte_in[0], working_byte_in[7:1]};
      LMD_FN_RORC: begin
        wr_next = {carry_in, working_byte_in[7:1]};
        carry_next = working_byte_in[0];
      end
      LMD_FN_SWAP:   wr_next = {working_byte_in[3:0], working_byte_in[7:4]};
      LMD_FN_TRADE: begin
        wr_next = working_byte_in;
        acc_next = y_val;
      end
      LMD_FN_DIGIT: begin
        wr_next = {y_val[7:4], working_byte_in[3:0]};
        acc_next = {working_byte_in[7:4], y_val[3:0]};
      end
      LMD_FN_PASS:   wr_next = y_val;
    endcase
    // Single-operand forms and loads into the accumulator land in the accumulator itself.
    if (dec_next.fn != LMD_FN_TRADE && dec_next.fn != LMD_FN_DIGIT &&
        (dec_next.dst == LMD_LOC_ACC || dec_next.dst == LMD_LOC_NONE)) begin
      acc_next = wr_next;
    end
  end

  // ****************************************************************
  // Result registers, captured when an instruction is taken
  // ****************************************************************

  // Results stand until the next instruction is taken, so the core may sample late.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dec <= '0;
      working_byte_out <= LMD_BYTE_ZERO;
      wr_data <= LMD_BYTE_ZERO;
      carry_out <= 1'b0;
      code_addr <= LMD_PTR_RESET;
      ext_addr <= LMD_PTR_RESET;
      reg_addr <= LMD_BYTE_ZERO;
    end else if (take) begin
      dec <= dec_next;
      working_byte_out <= acc_next;
      wr_data <= wr_next;
      carry_out <= carry_next;
      code_addr <= (dec_next.src == LMD_LOC_CODE_PC) ? pc_in + {8'h00, working_byte_in}
                                                    : data_pointer + {8'h00, working_byte_in};
      ext_addr <= (dec_next.src == LMD_LOC_EXT_DP || dec_next.dst == LMD_LOC_EXT_DP)
                  ? data_pointer : {8'h00, pointer_value};
      reg_addr <= {3'b000, bank_sel, dec_next.reg_idx};
    end
  end

  // Data pointer; high byte is the second instruction byte, low byte the third.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      data_pointer <= LMD_PTR_RESET;
    end else if (take && dec_next.dst == LMD_LOC_DATA_PTR) begin
      data_pointer <= {byte2, byte3};
    end
  end

  // ****************************************************************
  // Machine-cycle sequencing
  // ****************************************************************
  logic [15:0] cnt_reg;

  // Busy covers all machine cycles, so a new instruction waits until done.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busy <= 1'b0;
      done <= 1'b0;
      cnt_reg <= 16'h0000;
    end else begin
      done <= 1'b0;
      if (take) begin
        busy <= 1'b1;
        cnt_reg <= 16'((int'(dec_next.cycles) * MCYCLE_CLKS) - 1);
      end else if (busy) begin
        if (cnt_reg == 16'h0000) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - 16'h0001;
        end
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic [15:0] run_len;
  always_ff @(posedge clk) begin
    if (!reset_n || take) begin
      run_len <= 16'h0001;
    end else if (busy) begin
      run_len <= run_len + 16'h0001;
    end
  end

  chk_and_acc: assert property (take && opcode[7:3] == 5'b01011 |=> dec.fn == LMD_FN_AND &&
    dec.cycles == 2'h1 && dec.src == LMD_LOC_REG && wr_data == ($past(working_byte_in) & $past(src_data)))
    else $error("and with bank register decoded wrong");
  chk_and_direct: assert property (take && opcode == 8'h53 |=> dec.bytes == 2'h3 && dec.cycles == 2'h2
    && wr_data == ($past(dst_data) & $past(byte3))) else $error("and immediate into direct byte wrong");
  chk_or_acc: assert property (take && opcode == 8'h44 |=> dec.bytes == 2'h2 &&
    working_byte_out == ($past(working_byte_in) | $past(byte2))) else $error("or immediate into accumulator wrong");
  chk_or_direct: assert property (take && opcode == 8'h42 |=> dec.dst == LMD_LOC_DIRECT && dec.cycles == 2'h1
    && working_byte_out == $past(working_byte_in)) else $error("or into direct byte wrong");
  chk_xor_acc: assert property (take && opcode == 8'h65 |=> dec.src == LMD_LOC_DIRECT &&
    working_byte_out == ($past(working_byte_in) ^ $past(src_data))) else $error("xor direct into accumulator wrong");
  chk_xor_direct: assert property (take && opcode == 8'h63 |-> ##1 busy ##1 busy && !done ##1 done)
    else $error("xor immediate into direct byte did not take two cycles");
  chk_rotate_carry: assert property (take && opcode == 8'h33 |=> carry_out == $past(working_byte_in[7]) &&
    working_byte_out == {$past(working_byte_in[6:0]), $past(carry_in)}) else $error("rotate left through carry wrong");
  chk_rotate_right: assert property (take && opcode == 8'h03 |=>
    working_byte_out == {$past(working_byte_in[0]), $past(working_byte_in[7:1])}) else $error("rotate right wrong");
  chk_nibble_swap: assert property (take && opcode == 8'hC4 |=>
    working_byte_out == {$past(working_byte_in[3:0]), $past(working_byte_in[7:4])}) else $error("swap wrong");
  chk_pointer_load: assert property (take && opcode == 8'h90 |=> data_pointer == {$past(byte2), $past(byte3)}
    ##1 $stable(data_pointer)) else $error("data pointer load wrong");
  chk_low_digit: assert property (take && opcode[7:1] == 7'h6B |=>
    wr_data[3:0] == $past(working_byte_in[3:0]) && working_byte_out[7:4] == $past(working_byte_in[7:4]))
    else $error("low digit trade wrong");
  chk_bank_index: assert property (take && opcode[7:3] == 5'b11101 |=> reg_addr[2:0] == $past(opcode[2:0])
    && reg_addr[4:3] == $past(bank_sel)) else $error("bank register index wrong");
  chk_run_length: assert property (done |-> $past(run_len) == 16'(int'(dec.cycles) * MCYCLE_CLKS))
    else $error("machine cycle count wrong");

  cov_two_cycle: cover property (take && dec_next.cycles == 2'h2 ##[1:8] done);
  cov_trade: cover property (take && dec_next.fn == LMD_FN_TRADE);
  cov_ext_write: cover property (take && dec_next.dst == LMD_LOC_EXT_DP);
  cov_back_to_back: cover property (done ##1 take);

endmodule : lmd_decoder

/* dv/lmd_mem_model.sv */
// ********************
// Operand memory model
// ********************
module lmd_mem_model
  import lmd_pkg::*;
(
  // Instruction being fetched.
  input  wire logic [7:0] opcode,
  input  wire logic [7:0] byte2,
  input  wire logic [1:0] bank_sel,
  // Operands handed to the core.
  output logic [7:0]      src_data,
  output logic [7:0]      dst_data,
  output logic [7:0]      pointer_value
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] ri_addr;

  // A fixed scrambled image stands in for RAM, so no two addresses read alike.
  function automatic logic [7:0] ram(input logic [7:0] a);
    return {a[3:0], a[7:4]} ^ 8'hA5;
  endfunction : ram

  // Pointer register is R0 or R1 of the selected bank.
  assign ri_addr       = {3'b000, bank_sel, 2'b00, opcode[0]};
  assign pointer_value = ram(ri_addr);
  assign dst_data      = ram(byte2);

  // Source operand by addressing form; other forms see the second byte.
  always_comb begin
    if (opcode[3]) begin
      src_data = ram({3'b000, bank_sel, opcode[2:0]});
    end else if (opcode[3:1] == 3'b011) begin
      src_data = ram(pointer_value);
    end else if (opcode[3:0] == 4'h5) begin
      src_data = ram(byte2);
    end else begin
      src_data = byte2;
    end
  end
endmodule : lmd_mem_model

/* dv/tb.sv */
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; $display("Error %0t got %h exp %h", $time, a, b); end end
// ********************
// Testbench
// ********************
module tb;
  import lmd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        start = 1'b0;
  logic        carry_in = 1'b0;
  logic [7:0]  opcode = 8'h00;
  logic [7:0]  byte2 = 8'h00;
  logic [7:0]  byte3 = 8'h00;
  logic [7:0]  acc = 8'h00;
  logic [1:0]  bank_sel = 2'h0;
  logic [15:0] pc_in = 16'h0000;
  wire  [7:0]  src_data;
  wire  [7:0]  dst_data;
  wire  [7:0]  pointer_value;
  logic        busy;
  logic        done;
  logic        carry_out;
  lmd_dec_t    dec;
  logic [7:0]  wbo;
  logic [7:0]  wr_data;
  logic [7:0]  reg_addr;
  logic [15:0] data_pointer;
  logic [15:0] code_addr;
  logic [15:0] ext_addr;
  int          fails = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          ncyc;

  lmd_decoder uut (.clk(clk), .reset_n(reset_n), .start(start), .opcode(opcode), .byte2(byte2),
    .byte3(byte3), .working_byte_in(acc), .carry_in(carry_in), .src_data(src_data), .dst_data(dst_data),
    .pointer_value(pointer_value), .bank_sel(bank_sel), .pc_in(pc_in), .busy(busy), .done(done),
    .dec(dec), .working_byte_out(wbo), .wr_data(wr_data), .carry_out(carry_out),
    .data_pointer(data_pointer), .code_addr(code_addr), .ext_addr(ext_addr), .reg_addr(reg_addr));

  lmd_mem_model mem (.opcode(opcode), .byte2(byte2), .bank_sel(bank_sel), .src_data(src_data),
    .dst_data(dst_data), .pointer_value(pointer_value));

  // Clock at 40 MHz.
  always #12.5 clk = ~clk;

  // Cycle ceiling cuts a hang short; the whole run needs well under a thousand.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      give_verdict();
    end
  end

  task give_verdict;
    if (fails == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  // One instruction: offered for one edge, then done is awaited and the cycles counted.
  task run(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] b3, input logic [7:0] a, input int ec);
    @(posedge clk);
    start  <= 1'b1;
    opcode <= op;
    byte2  <= b2;
    byte3  <= b3;
    acc    <= a;
    @(posedge clk);
    start <= 1'b0;
    #1;
    `CHK(busy, 1'b1)
    ncyc = 0;
    do begin
      @(posedge clk);
      #1;
      ncyc++;
    end while (done !== 1'b1 && ncyc < 8);
    `CHK(ncyc, ec)
  endtask : run

  function automatic logic [7:0] f(input logic [7:0] op, input logic [7:0] x, input logic [7:0] y);
    case (op[7:4])
      4'h5: return x & y;
      4'h4: return x | y;
      default: return x ^ y;
    endcase
  endfunction : f

  // Logic into the accumulator, every addressing form.
  task t_logic_acc;
    logic [7:0] ops [12] = '{8'h54, 8'h5D, 8'h55, 8'h57, 8'h44, 8'h4A, 8'h45, 8'h46, 8'h64, 8'h6F, 8'h65, 8'h66};
    for (int i = 0; i < 12; i++) begin
      run(ops[i], 8'h3C, 8'h00, 8'h96, 1);
      `CHK(wbo, f(ops[i], 8'h96, src_data))
    end
  endtask : t_logic_acc

  // Logic into a direct byte; immediate forms are three bytes and two cycles.
  task t_logic_dir;
    logic [7:0] ops [6] = '{8'h52, 8'h53, 8'h42, 8'h43, 8'h62, 8'h63};
    for (int i = 0; i < 6; i++) begin
      run(ops[i], 8'h40, 8'h0F, 8'h96, ops[i][0] ? 2 : 1);
      `CHK(wr_data, f(ops[i], dst_data, ops[i][0] ? 8'h0F : 8'h96))
      `CHK(dec.bytes, ops[i][0] ? 2'h3 : 2'h2)
    end
  endtask : t_logic_dir

  // Rotates, nibble swap, clear and invert with the carry flag set.
  task t_rotate;
    logic [7:0] ops [7] = '{8'h23, 8'h33, 8'h03, 8'h13, 8'hC4, 8'hE4, 8'hF4};
    logic [7:0] exp [7] = '{8'h2D, 8'h2D, 8'h4B, 8'hCB, 8'h69, 8'h00, 8'h69};
    for (int i = 0; i < 7; i++) begin
      run(ops[i], 8'h00, 8'h00, 8'h96, 1);
      `CHK(wbo, exp[i])
      if (i == 1) `CHK(carry_out, 1'b1)
      if (i == 3) `CHK(carry_out, 1'b0)
    end
  endtask : t_rotate

  // Copies between locations; the direct load lands in the accumulator.
  task t_moves;
    logic [7:0] ops [14] = '{8'hE5, 8'hEB, 8'h74, 8'hFA, 8'hA9, 8'h7B, 8'hF5, 8'h8C, 8'h85, 8'h86, 8'h75, 8'hF6, 8'hA6, 8'h76};
    int cy [14] = '{1, 1, 1, 1, 2, 1, 1, 2, 2, 2, 2, 1, 2, 1};
    for (int i = 0; i < 14; i++) begin
      run(ops[i], 8'h40, 8'hA7, 8'h5A, cy[i]);
    end
    `CHK(wr_data, 8'h40)
    run(8'hE5, 8'h40, 8'h00, 8'h5A, 1);
    `CHK(wbo, src_data)
    run(8'h75, 8'h40, 8'hA7, 8'h5A, 2);
    `CHK(wr_data, 8'hA7)
  endtask : t_moves

  // Register numbering and indirect pointers in bank 2.
  task t_regs;
    @(posedge clk);
    bank_sel <= 2'h2;
    run(8'h7B, 8'h55, 8'h00, 8'h5A, 1);
    `CHK(reg_addr, 8'h13)
    `CHK(wr_data, 8'h55)
    run(8'h77, 8'h66, 8'h00, 8'h5A, 1);
    `CHK(reg_addr, 8'h11)
    run(8'hE6, 8'h00, 8'h00, 8'h5A, 1);
    `CHK(wbo, src_data)
  endtask : t_regs

  // Data pointer load, code table and external memory addressing.
  task t_pointer;
    @(posedge clk);
    pc_in <= 16'h0100;
    run(8'h90, 8'h12, 8'h34, 8'h10, 2);
    `CHK(data_pointer, 16'h1234)
    run(8'h93, 8'h00, 8'h00, 8'h10, 2);
    `CHK(code_addr, 16'h1244)
    run(8'h83, 8'h00, 8'h00, 8'h10, 2);
    `CHK(code_addr, 16'h0110)
    run(8'hE0, 8'h00, 8'h00, 8'h10, 2);
    `CHK(ext_addr, 16'h1234)
    run(8'hE3, 8'h00, 8'h00, 8'h10, 2);
    `CHK(ext_addr, {8'h00, pointer_value})
    run(8'hF0, 8'h00, 8'h00, 8'h3E, 2);
    `CHK(wr_data, 8'h3E)
    run(8'hF2, 8'h00, 8'h00, 8'h3E, 2);
    `CHK(ext_addr, {8'h00, pointer_value})
  endtask : t_pointer

  // Trades with the accumulator and stack transfers.
  task t_trade;
    run(8'hC5, 8'h40, 8'h00, 8'h96, 1);
    `CHK(wbo, src_data)
    `CHK(wr_data, 8'h96)
    run(8'hCA, 8'h00, 8'h00, 8'h96, 1);
    `CHK(wbo, src_data)
    run(8'hD6, 8'h00, 8'h00, 8'h96, 1);
    `CHK(wbo, {4'h9, src_data[3:0]})
    `CHK(wr_data, {src_data[7:4], 4'h6})
    run(8'hC0, 8'h40, 8'h00, 8'h96, 2);
    run(8'hD0, 8'h40, 8'h00, 8'h96, 2);
    `CHK(dec.bytes, 2'h2)
  endtask : t_trade

  // Foreign opcode is taken as not legal; a request held high while busy is ignored.
  task t_refuse;
    run(8'h24, 8'h00, 8'h00, 8'h5A, 1);
    `CHK(dec.legal, 1'b0)
    @(posedge clk);
    start  <= 1'b1;
    opcode <= 8'h90;
    byte2  <= 8'h56;
    byte3  <= 8'h78;
    @(posedge clk);
    byte2 <= 8'hAA;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    #1;
    `CHK(done, 1'b1)
    `CHK(data_pointer, 16'h5678)
    `CHK(dec.legal, 1'b1)
  endtask : t_refuse

  // Reset, then the scenarios in turn.
  initial begin
    repeat (3) @(posedge clk);
    reset_n  <= 1'b1;
    carry_in <= 1'b1;
    #1;
    `CHK(busy, 1'b0)
    `CHK(dec.legal, 1'b0)
    t_logic_acc();
    t_logic_dir();
    t_rotate();
    t_moves();
    t_regs();
    t_pointer();
    t_trade();
    t_refuse();
    give_verdict();
  end
endmodule : tb
